// [rtl/bmsnpe_pkg.sv]
package bmsnpe_pkg;
   // Message type and severity codes
   localparam logic [3:0] TYPE_FIXED     = 4'h1;
   localparam logic [3:0] TYPE_DEBUG     = 4'h2;
   localparam logic [3:0] LVL_DEBUG      = 4'h0;
   localparam logic [3:0] LVL_INFORM     = 4'h1;
   localparam logic [3:0] LVL_WARN       = 4'h2;
   localparam logic [3:0] LVL_CRITICAL   = 4'h3;
   localparam logic [3:0] LVL_FATAL      = 4'h4;
   localparam logic [3:0] LVL_MAX        = 4'h4;
   // Event codes
   localparam logic [7:0] EV_NO_SENSOR_BASE  = 8'h3d;
   localparam logic [7:0] EV_NO_SENSOR_LAST  = 8'h42;
   localparam logic [3:0] SENSOR_CH_FIRST    = 4'h3;
   localparam logic [3:0] SENSOR_CH_LAST     = 4'h8;
   localparam logic [7:0] EV_MODE_BASE       = 8'h46;
   localparam logic [7:0] EV_MODE_LAST       = 8'h4c;
   localparam logic [7:0] EV_SELF_TEST_DONE  = 8'h4d;
   localparam logic [7:0] EV_UNSUPPORTED     = 8'h4e;
   localparam logic [7:0] EV_READBACK_FAIL   = 8'h4f;
   localparam logic [7:0] EV_EXT_IRQ_UNDEF   = 8'h52;
   localparam logic [3:0] EXT_IRQ_CH_FIRST   = 4'h5;
   localparam logic [3:0] EXT_IRQ_CH_LAST    = 4'hf;
   localparam logic [7:0] EV_BAL_LOWER       = 8'h53;
   localparam logic [7:0] EV_BAL_UPPER       = 8'h54;
   // Operating mode index, order matches event codes 0x46..0x4c
   localparam logic [2:0] OPM_DEGRADED = 3'h0;
   localparam logic [2:0] OPM_IDLE     = 3'h1;
   localparam logic [2:0] OPM_IDLE_NFE = 3'h2;
   localparam logic [2:0] OPM_RUN      = 3'h3;
   localparam logic [2:0] OPM_SHUTDOWN = 3'h4;
   localparam logic [2:0] OPM_REDUCED  = 3'h5;
   localparam logic [2:0] OPM_TEST     = 3'h6;
   // Task state, power mode, rail bits
   localparam logic [7:0] TASK_LAST       = 8'h05;
   localparam logic [7:0] PMODE_SHUTDOWN  = 8'h01;
   localparam logic [7:0] PMODE_IDLE      = 8'h02;
   localparam logic [7:0] PMODE_IDLE_NFE  = 8'h03;
   localparam logic [7:0] PMODE_RUN       = 8'h04;
   localparam logic [7:0] PMODE_TEST      = 8'h05;
   localparam int         RAIL_COUNT      = 6;
   localparam logic [3:0] DBG_MOD_FIRST   = 4'h1;
   localparam logic [3:0] DBG_MOD_LAST    = 4'hf;
   // Event sources in the interrupt status layout
   localparam int         EV_COUNT        = 8;
   localparam int         EVB_SENSOR      = 0;
   localparam int         EVB_MODE        = 1;
   localparam int         EVB_SELF_TEST   = 2;
   localparam int         EVB_UNSUPPORTED = 3;
   localparam int         EVB_READBACK    = 4;
   localparam int         EVB_EXT_IRQ     = 5;
   localparam int         EVB_BALANCE     = 6;
   localparam int         EVB_DEBUG       = 7;
   // Wishbone register offsets (byte addresses)
   localparam logic [7:0] REG_CTRL     = 8'h00;
   localparam logic [7:0] REG_STATUS   = 8'h04;
   localparam logic [7:0] REG_MASK     = 8'h08;
   localparam logic [7:0] REG_PAY_LO   = 8'h0c;
   localparam logic [7:0] REG_PAY_HI   = 8'h10;
   localparam logic [7:0] REG_BUILD    = 8'h14;
   localparam logic [7:0] REG_FRAMES   = 8'h18;
   // Reset values
   localparam logic [7:0]  CTRL_RST    = 8'h01;
   localparam logic [15:0] BUILD_RST   = 16'h0000;
   localparam logic [7:0]  MASK_RST    = 8'h00;
   // Control register fields
   localparam int CTRL_EN_BIT      = 0;
   localparam int CTRL_LVL_LSB     = 4;
endpackage : bmsnpe_pkg

// [rtl/bmsnpe_encoder.sv]
// Behaviour
// (R1) Type upper nibble, severity lower nibble, byte 0
// (R2) Severity 0..4, type fixed 1, debug 2
// (R3) Fixed: code, task, rails, mode, 0, build
// (R4) Missing sensor channels 3..8 give 0x3d..0x42
// (R5) Mode changes give codes 0x46..0x4c in order
// (R6) Unsupported request 0x4e, self test done 0x4d
// (R7) Readback mismatch reports code 0x4f
// (R8) Undefined ext interrupt 5..15 gives 0x52
// (R9) Balancing start: lower 0x53, upper 0x54
// (R10) Task state byte codes 0 to 5
// (R11) Rail status bit n high when rail on
// (R12) Power mode byte codes 1 to 5
// (R13) Debug: module byte 1, data 2..4, rest 0
// (R14) Debug module identifiers 1 to 15
// (R15) Debug data is a free reference value
// (R16) Status latched with event; whole frame presented
//
// Our own choices: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
module bmsnpe_encoder (
   input  wire logic        ref_clk,
   input  wire logic        rst_b,
   input  wire logic [31:0] wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic        wb_we_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic             wb_err_o,
   input  wire logic [3:0]  sensor_missing_ch,
   input  wire logic        sensor_missing_event,
   input  wire logic [2:0]  mode_changed_to,
   input  wire logic        mode_change_event,
   input  wire logic        power_on_self_test_done,
   input  wire logic        unsupported_request_event,
   input  wire logic        readback_mismatch_event,
   input  wire logic [3:0]  ext_irq_ch,
   input  wire logic        undefined_ext_irq_event,
   input  wire logic        balance_upper,
   input  wire logic        balance_start_event,
   input  wire logic [3:0]  debug_module_id,
   input  wire logic [23:0] debug_reference,
   input  wire logic        debug_event,
   input  wire logic [7:0]  task_state,
   input  wire logic [5:0]  rail_on,
   input  wire logic [7:0]  power_mode,
   output logic      [63:0] frame_payload,
   output logic             frame_valid,
   input  wire logic        frame_ready,
   output logic             event_busy,
   output logic             irq
);
   logic [7:0]  ctrl;
   logic [7:0]  next_ctrl;
   logic [15:0] build;
   logic [15:0] next_build;
   logic [7:0]  irq_status;
   logic [7:0]  next_irq_status;
   logic [7:0]  irq_mask;
   logic [7:0]  next_irq_mask;
   logic [15:0] frames_sent;
   logic [15:0] next_frames_sent;
   logic [31:0] next_wb_dat_o;
   logic        next_wb_ack_o;
   logic        next_wb_err_o;
   logic [63:0] next_frame_payload;
   logic        next_frame_valid;
   logic        next_irq;
   logic        next_event_busy;

   // Fixed frame: byte 0 type/level, then code, task, rails, mode, 0, build lo, build hi
   function automatic logic [63:0] fixed_frame(input logic [3:0] lvl, input logic [7:0] code,
                                               input logic [7:0] tsk, input logic [5:0] rails,
                                               input logic [7:0] pm, input logic [15:0] bld);
      fixed_frame = {bld[15:8], bld[7:0], 8'h00, pm, {2'h0, rails}, tsk, code,
                     bmsnpe_pkg::TYPE_FIXED, lvl}; // [R1] [R3] [R11]
   endfunction : fixed_frame

   // Event arbitration: one source is accepted per cycle, lowest index first
   logic                                  accept;
   logic [bmsnpe_pkg::EV_COUNT-1:0]        ev_req;
   logic [bmsnpe_pkg::EV_COUNT-1:0]        ev_hit;
   logic [7:0]                             ev_code;
   logic                                   ev_dbg;
   logic                                   sensor_ok;
   logic                                   irq_ok;
   logic                                   task_ok;
   logic                                   pm_ok;
   logic [3:0]                             lvl;
   logic                                   bus_req;
   logic                                   bus_hit;

   assign sensor_ok = sensor_missing_ch >= bmsnpe_pkg::SENSOR_CH_FIRST &&
                      sensor_missing_ch <= bmsnpe_pkg::SENSOR_CH_LAST;
   assign irq_ok    = ext_irq_ch >= bmsnpe_pkg::EXT_IRQ_CH_FIRST; // [R8]
   assign task_ok   = task_state <= bmsnpe_pkg::TASK_LAST; // [R10]
   assign pm_ok     = power_mode >= bmsnpe_pkg::PMODE_SHUTDOWN &&
                      power_mode <= bmsnpe_pkg::PMODE_TEST; // [R12]
   assign ev_req    = {debug_event && debug_module_id >= bmsnpe_pkg::DBG_MOD_FIRST, // [R14]
                       balance_start_event, undefined_ext_irq_event && irq_ok,
                       readback_mismatch_event, unsupported_request_event,
                       power_on_self_test_done, mode_change_event && mode_changed_to <= bmsnpe_pkg::OPM_TEST,
                       sensor_missing_event && sensor_ok};
   assign accept    = ctrl[bmsnpe_pkg::CTRL_EN_BIT] && (!frame_valid || frame_ready) && (ev_req != '0);
   assign ev_hit    = ev_req & (~ev_req + 8'h01);
   assign lvl       = (ctrl[bmsnpe_pkg::CTRL_LVL_LSB +: 4] > bmsnpe_pkg::LVL_MAX) ?
                      bmsnpe_pkg::LVL_MAX : ctrl[bmsnpe_pkg::CTRL_LVL_LSB +: 4]; // [R2]
   assign bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;

   always_comb begin
      ev_code = 8'h00;
      ev_dbg  = 1'b0;
      unique case (1'b1)
         ev_hit[bmsnpe_pkg::EVB_SENSOR]:
            ev_code = bmsnpe_pkg::EV_NO_SENSOR_BASE + {4'h0, sensor_missing_ch - bmsnpe_pkg::SENSOR_CH_FIRST}; // [R4]
         ev_hit[bmsnpe_pkg::EVB_MODE]:
            ev_code = bmsnpe_pkg::EV_MODE_BASE + {5'h00, mode_changed_to}; // [R5]
         ev_hit[bmsnpe_pkg::EVB_SELF_TEST]:   ev_code = bmsnpe_pkg::EV_SELF_TEST_DONE; // [R6]
         ev_hit[bmsnpe_pkg::EVB_UNSUPPORTED]: ev_code = bmsnpe_pkg::EV_UNSUPPORTED; // [R6]
         ev_hit[bmsnpe_pkg::EVB_READBACK]:    ev_code = bmsnpe_pkg::EV_READBACK_FAIL; // [R7]
         ev_hit[bmsnpe_pkg::EVB_EXT_IRQ]:     ev_code = bmsnpe_pkg::EV_EXT_IRQ_UNDEF; // [R8]
         ev_hit[bmsnpe_pkg::EVB_BALANCE]:
            ev_code = balance_upper ? bmsnpe_pkg::EV_BAL_UPPER : bmsnpe_pkg::EV_BAL_LOWER; // [R9]
         ev_hit[bmsnpe_pkg::EVB_DEBUG]:       ev_dbg = 1'b1;
         default: ev_code = 8'h00;
      endcase
   end

   // Frame and status path
   always_comb begin
      next_frame_payload = frame_payload;
      next_frame_valid   = frame_valid && !frame_ready;
      next_frames_sent   = frames_sent;
      next_event_busy    = (ev_req != '0) && !accept;
      if (accept) begin
         next_frame_valid = 1'b1; // [R16]
         next_frames_sent = frames_sent + 16'h0001;
         if (ev_dbg) begin
            next_frame_payload = {24'h000000, debug_reference, debug_module_id == 4'h0 ? 8'h00 :
                                  {4'h0, debug_module_id}, bmsnpe_pkg::TYPE_DEBUG, lvl}; // [R13] [R15]
         end else begin
            next_frame_payload = fixed_frame(lvl, ev_code, task_ok ? task_state : 8'h00,
                                             rail_on, pm_ok ? power_mode : 8'h00, build); // [R16]
         end
      end
   end

   // Wishbone slave and interrupt registers
   always_comb begin
      next_ctrl       = ctrl;
      next_build      = build;
      next_irq_mask   = irq_mask;
      next_irq_status = irq_status;
      next_wb_dat_o   = 32'h00000000;
      next_wb_ack_o   = 1'b0;
      next_wb_err_o   = 1'b0;
      bus_hit         = 1'b1;
      if (bus_req) begin
         unique case (wb_adr_i[7:0])
            bmsnpe_pkg::REG_CTRL: begin
               next_wb_dat_o = {24'h000000, ctrl};
               if (wb_we_i && wb_sel_i[0]) next_ctrl = wb_dat_i[7:0];
            end
            bmsnpe_pkg::REG_STATUS: begin
               next_wb_dat_o = {24'h000000, irq_status};
               if (!wb_we_i) next_irq_status = 8'h00;
            end
            bmsnpe_pkg::REG_MASK: begin
               next_wb_dat_o = {24'h000000, irq_mask};
               if (wb_we_i && wb_sel_i[0]) next_irq_mask = wb_dat_i[7:0];
            end
            bmsnpe_pkg::REG_PAY_LO: next_wb_dat_o = frame_payload[31:0];
            bmsnpe_pkg::REG_PAY_HI: next_wb_dat_o = frame_payload[63:32];
            bmsnpe_pkg::REG_BUILD: begin
               next_wb_dat_o = {16'h0000, build};
               if (wb_we_i && wb_sel_i[0]) next_build[7:0]  = wb_dat_i[7:0];
               if (wb_we_i && wb_sel_i[1]) next_build[15:8] = wb_dat_i[15:8];
            end
            bmsnpe_pkg::REG_FRAMES: next_wb_dat_o = {16'h0000, frames_sent};
            default: bus_hit = 1'b0;
         endcase
         if (wb_adr_i[31:8] != 24'h000000) bus_hit = 1'b0;
         if (!bus_hit) begin
            next_ctrl       = ctrl;
            next_build      = build;
            next_irq_mask   = irq_mask;
            next_irq_status = irq_status;
            next_wb_dat_o   = 32'h00000000;
         end
         next_wb_ack_o = bus_hit;
         next_wb_err_o = !bus_hit;
      end
      // Accepted events set sticky bits; a set wins over a read clear
      if (accept) next_irq_status = next_irq_status | ev_hit;
      next_irq = (next_irq_status & next_irq_mask) != 8'h00;
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl          <= bmsnpe_pkg::CTRL_RST;
         build         <= bmsnpe_pkg::BUILD_RST;
         irq_mask      <= bmsnpe_pkg::MASK_RST;
         irq_status    <= 8'h00;
         frames_sent   <= 16'h0000;
         wb_dat_o      <= 32'h00000000;
         wb_ack_o      <= 1'b0;
         wb_err_o      <= 1'b0;
         frame_payload <= 64'h0000000000000000;
         frame_valid   <= 1'b0;
         event_busy    <= 1'b0;
         irq           <= 1'b0;
      end else begin
         ctrl          <= next_ctrl;
         build         <= next_build;
         irq_mask      <= next_irq_mask;
         irq_status    <= next_irq_status;
         frames_sent   <= next_frames_sent;
         wb_dat_o      <= next_wb_dat_o;
         wb_ack_o      <= next_wb_ack_o;
         wb_err_o      <= next_wb_err_o;
         frame_payload <= next_frame_payload;
         frame_valid   <= next_frame_valid;
         event_busy    <= next_event_busy;
         irq           <= next_irq;
      end
   end

   // Checks
   property p_byte0_type;
      @(posedge ref_clk) disable iff (!rst_b)
      accept |=> frame_payload[7:4] == ($past(ev_dbg) ? bmsnpe_pkg::TYPE_DEBUG : bmsnpe_pkg::TYPE_FIXED);
   endproperty
   a_byte0_type: assert property (p_byte0_type) else $error("byte 0 type nibble wrong"); // [R1]
   property p_level_range;
      @(posedge ref_clk) disable iff (!rst_b)
      frame_valid |-> frame_payload[3:0] <= bmsnpe_pkg::LVL_MAX;
   endproperty
   a_level_range: assert property (p_level_range) else $error("severity out of range"); // [R2]
   property p_fixed_layout;
      @(posedge ref_clk) disable iff (!rst_b)
      (accept && !ev_dbg) |=> frame_payload[47:40] == 8'h00 && frame_payload[63:48] == $past(build);
   endproperty
   a_fixed_layout: assert property (p_fixed_layout) else $error("fixed frame layout wrong"); // [R3]
   property p_sensor_code;
      @(posedge ref_clk) disable iff (!rst_b)
      (accept && ev_hit[bmsnpe_pkg::EVB_SENSOR]) |=>
      frame_payload[15:8] == 8'h3a + {4'h0, $past(sensor_missing_ch)};
   endproperty
   a_sensor_code: assert property (p_sensor_code) else $error("sensor code wrong"); // [R4]
   property p_mode_code;
      @(posedge ref_clk) disable iff (!rst_b)
      (accept && ev_hit[bmsnpe_pkg::EVB_MODE]) |=>
      frame_payload[15:8] == 8'h46 + {5'h00, $past(mode_changed_to)} &&
      frame_payload[15:8] <= bmsnpe_pkg::EV_MODE_LAST;
   endproperty
   a_mode_code: assert property (p_mode_code) else $error("mode code wrong"); // [R5]
   property p_self_test_code;
      @(posedge ref_clk) disable iff (!rst_b)
      (accept && ev_hit[bmsnpe_pkg::EVB_SELF_TEST]) |=> frame_payload[15:8] == bmsnpe_pkg::EV_SELF_TEST_DONE;
   endproperty
   a_self_test_code: assert property (p_self_test_code) else $error("self test code wrong"); // [R6]
   property p_readback;
      @(posedge ref_clk) disable iff (!rst_b)
      (accept && ev_hit[bmsnpe_pkg::EVB_READBACK]) |=> frame_payload[15:8] == bmsnpe_pkg::EV_READBACK_FAIL;
   endproperty
   a_readback: assert property (p_readback) else $error("readback code wrong"); // [R7]
   property p_ext_irq_code;
      @(posedge ref_clk) disable iff (!rst_b)
      (accept && ev_hit[bmsnpe_pkg::EVB_EXT_IRQ]) |=> frame_payload[15:8] == bmsnpe_pkg::EV_EXT_IRQ_UNDEF;
   endproperty
   a_ext_irq_code: assert property (p_ext_irq_code) else $error("ext interrupt code wrong"); // [R8]
   property p_balance_code;
      @(posedge ref_clk) disable iff (!rst_b)
      (accept && ev_hit[bmsnpe_pkg::EVB_BALANCE]) |=>
      frame_payload[15:8] == ($past(balance_upper) ? bmsnpe_pkg::EV_BAL_UPPER : bmsnpe_pkg::EV_BAL_LOWER);
   endproperty
   a_balance_code: assert property (p_balance_code) else $error("balance code wrong"); // [R9]
   property p_task_byte;
      @(posedge ref_clk) disable iff (!rst_b)
      (accept && !ev_dbg) |=>
      frame_payload[23:16] == (($past(task_state) <= bmsnpe_pkg::TASK_LAST) ? $past(task_state) : 8'h00);
   endproperty
   a_task_byte: assert property (p_task_byte) else $error("task state byte wrong"); // [R10]
   property p_rail_byte;
      @(posedge ref_clk) disable iff (!rst_b)
      (accept && !ev_dbg) |=> frame_payload[31:24] == {2'b00, $past(rail_on)};
   endproperty
   a_rail_byte: assert property (p_rail_byte) else $error("rail status byte wrong"); // [R11]
   property p_pmode_byte;
      @(posedge ref_clk) disable iff (!rst_b)
      (accept && !ev_dbg) |=>
      frame_payload[39:32] == (($past(power_mode) >= bmsnpe_pkg::PMODE_SHUTDOWN &&
                                $past(power_mode) <= bmsnpe_pkg::PMODE_TEST) ? $past(power_mode) : 8'h00);
   endproperty
   a_pmode_byte: assert property (p_pmode_byte) else $error("power mode byte wrong"); // [R12]
   property p_debug_tail;
      @(posedge ref_clk) disable iff (!rst_b)
      (accept && ev_dbg) |=> frame_payload[63:40] == 24'h000000 && frame_payload[7:4] == bmsnpe_pkg::TYPE_DEBUG;
   endproperty
   a_debug_tail: assert property (p_debug_tail) else $error("debug tail not zero"); // [R13]
   property p_debug_data;
      @(posedge ref_clk) disable iff (!rst_b)
      (accept && ev_dbg) |=>
      frame_payload[39:16] == $past(debug_reference) && frame_payload[15:8] == {4'h0, $past(debug_module_id)};
   endproperty
   a_debug_data: assert property (p_debug_data) else $error("debug module or data wrong"); // [R14] [R15]
   property p_frame_hold;
      @(posedge ref_clk) disable iff (!rst_b)
      (frame_valid && !frame_ready) |=> frame_valid && $stable(frame_payload);
   endproperty
   a_frame_hold: assert property (p_frame_hold) else $error("frame changed while waiting"); // [R16]
endmodule : bmsnpe_encoder

// [test/bmsnpe_tx_model.sv]
`timescale 1ns/1ps
module bmsnpe_tx_model (
   input  wire logic        ref_clk,
   input  wire logic        rst_b,
   input  wire logic        stall,
   input  wire logic        frame_valid,
   input  wire logic [63:0] frame_payload,
   output logic             frame_ready,
   output logic      [63:0] got_payload,
   output int               got_count
);
   // Takes one frame at each edge where valid meets ready; ready lags stall by one cycle
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         frame_ready <= 1'b0;
         got_payload <= 64'h0;
         got_count   <= 0;
      end else begin
         frame_ready <= !stall;
         if (frame_valid && frame_ready) begin
            got_payload <= frame_payload;
            got_count   <= got_count + 1;
         end
      end
   end
endmodule : bmsnpe_tx_model

// [test/bmsnpe_encoder_tb_top.sv]
`timescale 1ns/1ps
module bmsnpe_encoder_tb_top;
   typedef struct packed {logic [2:0] kind; logic [3:0] arg; logic [7:0] code;} bmsnpe_row_t;
   localparam logic [15:0] BLD  = 16'h1234;
   localparam logic [23:0] DREF = 24'h3c7e3c; // Byte-symmetric, so lane order does not matter
   logic        ref_clk, rst_b, wb_we, wb_cyc, wb_stb, wb_ack, wb_err, er, stall;
   logic        frame_valid, frame_ready, event_busy, irq;
   logic [31:0] wb_adr, wb_dat_w, wb_dat_r, rd;
   logic [3:0]  wb_sel, arg, lvl;
   logic [7:0]  ev, task_state, power_mode;
   logic [5:0]  rail_on;
   logic [63:0] frame_payload, got_payload, ex;
   int          got_count, err_count, comparisons, n0;
   bmsnpe_row_t rows [22] = '{'{0,3,8'h3d}, '{0,4,8'h3e}, '{0,5,8'h3f}, '{0,6,8'h40}, '{0,7,8'h41},
      '{0,8,8'h42}, '{1,0,8'h46}, '{1,1,8'h47}, '{1,2,8'h48}, '{1,3,8'h49}, '{1,4,8'h4a}, '{1,5,8'h4b},
      '{1,6,8'h4c}, '{2,0,8'h4d}, '{3,0,8'h4e}, '{4,0,8'h4f}, '{5,5,8'h52}, '{5,15,8'h52}, '{6,0,8'h53},
      '{6,1,8'h54}, '{7,1,8'h00}, '{7,15,8'h00}};

   bmsnpe_encoder bmsnpe_encoder_inst (.ref_clk(ref_clk), .rst_b(rst_b), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat_w),
      .wb_sel_i(wb_sel), .wb_we_i(wb_we), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_dat_o(wb_dat_r),
      .wb_ack_o(wb_ack), .wb_err_o(wb_err), .sensor_missing_ch(arg), .sensor_missing_event(ev[0]),
      .mode_changed_to(arg[2:0]), .mode_change_event(ev[1]), .power_on_self_test_done(ev[2]),
      .unsupported_request_event(ev[3]), .readback_mismatch_event(ev[4]), .ext_irq_ch(arg),
      .undefined_ext_irq_event(ev[5]), .balance_upper(arg[0]), .balance_start_event(ev[6]),
      .debug_module_id(arg), .debug_reference(DREF), .debug_event(ev[7]), .task_state(task_state),
      .rail_on(rail_on), .power_mode(power_mode), .frame_payload(frame_payload), .frame_valid(frame_valid),
      .frame_ready(frame_ready), .event_busy(event_busy), .irq(irq));
   bmsnpe_tx_model bmsnpe_tx_model_inst (.ref_clk(ref_clk), .rst_b(rst_b), .stall(stall),
      .frame_valid(frame_valid), .frame_payload(frame_payload), .frame_ready(frame_ready),
      .got_payload(got_payload), .got_count(got_count));

   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : print_verdict

   // Classic single Wishbone cycle; waits for ack or err, then releases
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
      int k;
      k = 0;
      @(posedge ref_clk);
      wb_cyc   <= 1'b1;
      wb_stb   <= 1'b1;
      wb_adr   <= {24'h000000, adr};
      wb_we    <= we;
      wb_dat_w <= dat;
      wb_sel   <= sel;
      do begin
         @(posedge ref_clk);
         k++;
      end while (wb_ack !== 1'b1 && wb_err !== 1'b1 && k < 20);
      chk("bus answer", {63'h0, k < 20}, 64'h1);
      rd = wb_dat_r;
      er = wb_err;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask : wb

   task automatic fire(input logic [2:0] kind, input logic [3:0] a);
      @(posedge ref_clk);
      ev[kind] <= 1'b1;
      arg      <= a;
      @(posedge ref_clk);
      ev <= 8'h00;
   endtask : fire

   task automatic wait_frame(input int n);
      int k;
      k = 0;
      while (got_count != n && k < 30) begin
         @(posedge ref_clk);
         k++;
      end
      chk("frame count", got_count, n);
   endtask : wait_frame

   function automatic logic [63:0] fixed_pay(input logic [7:0] code, input logic [3:0] l);
      return {BLD, 8'h00, power_mode, 2'b00, rail_on, task_state, code, 4'h1, l};
   endfunction : fixed_pay

   initial begin
      repeat (20000) @(posedge ref_clk);
      err_count++;
      print_verdict();
   end

   initial begin
      {rst_b, wb_we, wb_cyc, wb_stb, stall, ev, arg} <= '0;
      {wb_adr, wb_dat_w, wb_sel} <= '0;
      task_state <= 8'h03;
      rail_on    <= 6'h2a;
      power_mode <= 8'h04;
      repeat (8) @(posedge ref_clk);
      rst_b <= 1'b1;
      wb(0, bmsnpe_pkg::REG_CTRL, 0, 4'hf);
      chk("ctrl reset", rd, 32'h01);
      wb(0, bmsnpe_pkg::REG_BUILD, 0, 4'hf);
      chk("build reset", rd, 32'h0);
      wb(0, 8'h1c, 0, 4'hf);
      chk("unmapped err", er, 1);
      $display("test reset done");
      wb(1, bmsnpe_pkg::REG_CTRL, 32'h31, 4'hf);
      wb(1, bmsnpe_pkg::REG_BUILD, {16'h0, BLD}, 4'h3);
      lvl = 4'h3;
      foreach (rows[i]) begin
         ex = (rows[i].kind == 3'd7) ? {24'h0, DREF, 4'h0, rows[i].arg, 4'h2, lvl} : fixed_pay(rows[i].code, lvl);
         fire(rows[i].kind, rows[i].arg);
         wait_frame(i + 1);
         chk("payload", got_payload, ex);
      end
      wb(0, bmsnpe_pkg::REG_PAY_HI, 0, 4'hf);
      chk("payload high reg", rd, ex[63:32]);
      wb(0, bmsnpe_pkg::REG_STATUS, 0, 4'hf);
      chk("status all", rd, 32'hff);
      wb(0, bmsnpe_pkg::REG_STATUS, 0, 4'hf);
      chk("status cleared", rd, 32'h0);
      $display("test table done");
      for (int l = 0; l < 6; l++) begin
         wb(1, bmsnpe_pkg::REG_CTRL, {24'h0, (l == 5) ? 4'hf : l[3:0], 4'h1}, 4'hf);
         ex = fixed_pay(8'h4e, (l == 5) ? 4'h4 : l[3:0]);
         fire(3, 0);
         task_state <= task_state ^ 8'h01;
         wait_frame(got_count + 1);
         chk("severity and latch", got_payload, ex);
      end
      task_state <= 8'h09;
      power_mode <= 8'h07;
      fire(2, 0);
      wait_frame(got_count + 1);
      chk("bad task and mode", got_payload[39:16], {8'h00, 2'b00, rail_on, 8'h00});
      $display("test severity done");
      n0 = got_count;
      stall <= 1'b1;
      fire(2, 0);
      fire(4, 0);
      #1;
      chk("busy on refusal", event_busy, 1);
      repeat (3) @(posedge ref_clk);
      stall <= 1'b0;
      #1;
      chk("frame stands", {frame_valid, frame_payload[15:8]}, {1'b1, 8'h4d});
      wait_frame(n0 + 1);
      fire(0, 2);
      fire(0, 9);
      fire(1, 7);
      fire(5, 4);
      fire(7, 0);
      wb(1, bmsnpe_pkg::REG_CTRL, 32'h30, 4'hf);
      fire(2, 0);
      repeat (4) @(posedge ref_clk);
      chk("ignored and disabled", got_count, n0 + 1);
      $display("test refusal done");
      wb(1, bmsnpe_pkg::REG_CTRL, 32'h21, 4'hf);
      wb(0, bmsnpe_pkg::REG_STATUS, 0, 4'hf);
      wb(1, bmsnpe_pkg::REG_MASK, 32'h08, 4'hf);
      fire(2, 0);
      repeat (3) @(posedge ref_clk);
      #1;
      chk("masked irq", irq, 0);
      fire(3, 0);
      repeat (3) @(posedge ref_clk);
      #1;
      chk("unmasked irq", irq, 1);
      wb(0, bmsnpe_pkg::REG_STATUS, 0, 4'hf);
      chk("status bits", rd, 32'h0c);
      repeat (2) @(posedge ref_clk);
      #1;
      chk("irq cleared", irq, 0);
      wb(0, bmsnpe_pkg::REG_FRAMES, 0, 4'hf);
      chk("frames sent reg", rd, got_count);
      $display("test interrupt done");
      print_verdict();
   end
endmodule : bmsnpe_encoder_tb_top
